// >>> acl_pkg.sv
package acl_pkg;

    // ------------------------------------------------------------------
    // Node shape and cyclic connection identity
    // ------------------------------------------------------------------
    localparam int          NUM_CH         = 2;
    localparam int          VAL_W          = 16;
    localparam int          CNT_W          = 24;
    localparam logic [7:0]  INST_INPUT     = 8'h64;  // Input assembly 100.
    localparam logic [7:0]  INST_OUTPUT    = 8'h96;  // Output assembly 150.
    localparam logic [7:0]  INST_CONFIG    = 8'h69;  // Configuration assembly 105.
    localparam logic [7:0]  CFG_SIZE_ZERO  = 8'h00;
    localparam logic [7:0]  NODE_IN_BYTES  = 8'h04;
    localparam logic [7:0]  NODE_OUT_BYTES = 8'h04;

    // ------------------------------------------------------------------
    // Limit windows and reset values
    // ------------------------------------------------------------------
    localparam logic signed [15:0] SCL_LOW_MIN   = 16'sh8001;  // -32767.
    localparam logic signed [15:0] SCL_LOW_MAX   = 16'sh7ffe;  // 32766.
    localparam logic signed [15:0] SCL_LOW_RST   = 16'sh0000;
    localparam logic signed [15:0] SCL_HIGH_MIN  = 16'sh8002;  // -32766.
    localparam logic signed [15:0] SCL_HIGH_MAX  = 16'sh7fff;  // 32767.
    localparam logic signed [15:0] SCL_HIGH_RST  = 16'sh03e8;  // 1000.
    localparam logic [15:0]        PLAIN_LOW_RST  = 16'h0000;
    localparam logic [15:0]        PLAIN_HIGH_RST = 16'hffff;
    localparam logic [15:0]        SUBST_RST      = 16'h0000;

    // ------------------------------------------------------------------
    // Per-channel option bits
    // ------------------------------------------------------------------
    localparam int OPT_W        = 4;
    localparam int OPT_LOW_EN   = 0;
    localparam int OPT_HIGH_EN  = 1;
    localparam int OPT_FAULT_EN = 2;
    localparam int OPT_IDLE_EN  = 3;
    localparam logic [OPT_W-1:0] OPT_RST = 4'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 25;
    localparam int CYCLE_TIME_US  = 10000;
    localparam int CYCLE_CLKS     = CYCLE_TIME_US * CLK_MHZ;
    localparam int WATCHDOG_MULT  = 4;
    localparam int WATCHDOG_CLKS  = CYCLE_CLKS * WATCHDOG_MULT;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FMT_OFFSET_BIN = 2'b00,
        FMT_SIGN_MAG   = 2'b01,
        FMT_TWOS       = 2'b10,
        FMT_SCALED     = 2'b11
    } acl_fmt_t;

    typedef enum logic [2:0] {
        PAR_OPTIONS   = 3'b000,
        PAR_LOW       = 3'b001,
        PAR_HIGH      = 3'b010,
        PAR_SCL_LOW   = 3'b011,
        PAR_SCL_HIGH  = 3'b100,
        PAR_FAULT_VAL = 3'b101,
        PAR_IDLE_VAL  = 3'b110
    } acl_par_t;

    typedef enum logic {
        PRIO_NETWORK  = 1'b0,
        PRIO_HANDHELD = 1'b1
    } acl_prio_t;

    // Maps a value of any data format onto one signed scale for comparing.
    function automatic logic signed [16:0] acl_key(input logic [15:0] v, input acl_fmt_t f);
        logic signed [16:0] k;
        k = {v[15], v};
        unique case (f)
            FMT_OFFSET_BIN: k = {1'b0, v} - 17'sh08000;
            FMT_SIGN_MAG:   k = v[15] ? -$signed({2'b00, v[14:0]}) : $signed({2'b00, v[14:0]});
            FMT_TWOS,
            FMT_SCALED:     k = {v[15], v};
        endcase
        return k;
    endfunction : acl_key

    // Forces a signed value into a window.
    function automatic logic [15:0] acl_clamp(input logic signed [15:0] v,
                                              input logic signed [15:0] lo,
                                              input logic signed [15:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : acl_clamp

endpackage : acl_pkg

// >>> acl_link_if.sv
`timescale 1ns/1ps
interface acl_link_if;
    import acl_pkg::*;

    // ------------------------------------------------------------------
    // Connection request and cyclic data
    // ------------------------------------------------------------------
    logic                          connOpen;
    logic [7:0]                    inInst;
    logic [7:0]                    outInst;
    logic [7:0]                    cfgInst;
    logic [7:0]                    inSize;
    logic [7:0]                    outSize;
    logic [7:0]                    cfgSize;
    logic                          outValid;
    logic [NUM_CH*VAL_W-1:0]       outData;
    logic                          runMode;
    logic                          connAccepted;
    logic                          inValid;
    logic [NUM_CH*VAL_W-1:0]       inData;
    logic [2*NUM_CH-1:0]           chanErr;

    modport host (
        output connOpen, inInst, outInst, cfgInst, inSize, outSize, cfgSize,
        output outValid, outData, runMode,
        input  connAccepted, inValid, inData, chanErr
    );

    modport dev (
        input  connOpen, inInst, outInst, cfgInst, inSize, outSize, cfgSize,
        input  outValid, outData, runMode,
        output connAccepted, inValid, inData, chanErr
    );

endinterface : acl_link_if

// >>> acl_limit_check.sv
`timescale 1ns/1ps
module acl_limit_check
    import acl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [15:0] value,
    input  wire logic [15:0] lowBound,
    input  wire logic [15:0] highBound,
    input  wire logic       lowEn,
    input  wire logic       highEn,
    input  wire acl_fmt_t   dataFormat,
    output logic            lowErr,
    output logic            highErr
);

    logic lowErr_d;
    logic highErr_d;
    logic lowErr_q;
    logic highErr_q;

    // Compares in the encoding of the selected format; flags follow the level.
    always_comb begin
        lowErr_d  = lowEn && (acl_key(value, dataFormat) < acl_key(lowBound, dataFormat));   // [R1]
        highErr_d = highEn && (acl_key(value, dataFormat) > acl_key(highBound, dataFormat)); // [R13]
    end

    // Registers the flags; they stay up while the violation persists.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowErr_q  <= 1'b0;
            highErr_q <= 1'b0;
        end else begin
            lowErr_q  <= lowErr_d;  // [R15]
            highErr_q <= highErr_d; // [R15]
        end
    end

    assign lowErr  = lowErr_q;
    assign highErr = highErr_q;

endmodule : acl_limit_check

// >>> acl_device_end.sv
`timescale 1ns/1ps
// How it works
// [R1] Enabled lower check flags values below bound.
// [R2] Scaled low bound clamped, default zero.
// [R3] Comm fault drives fault value if enabled.
// [R4] Comm idle drives idle value if enabled.
// [R5] Substitution only under handheld hold/clear priority.
// [R6] Scaled format uses scaled bounds instead.
// [R7] Configurer keeps values inside range window.
// [R8] Configurer rechecks values after range change.
// [R9] Connection uses instances 100, 150, 105.
// [R10] Configuration size zero, sizes match node.
// [R11] Size mismatch makes the connection invalid.
// [R12] Total node data size is even.
// [R13] Enabled upper check flags values above bound.
// [R14] Scaled high bound clamped, default 1000.
// [R15] Compare in format encoding; flag persists.
module acl_device_end
    import acl_pkg::*;
#(
    parameter int WATCHDOG = WATCHDOG_CLKS
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    acl_link_if.dev                         link,
    input  wire acl_fmt_t                   dataFormat,
    input  wire acl_prio_t                  holdPriority,
    input  wire logic                       parWrite,
    input  wire logic                       parChan,
    input  wire acl_par_t                   parSel,
    input  wire logic [15:0]                parData,
    input  wire logic [NUM_CH-1:0][15:0]    adcValue,
    output logic [NUM_CH-1:0][15:0]         dacValue,
    output logic [NUM_CH-1:0]               inChanErr,
    output logic [NUM_CH-1:0]               outChanErr,
    output logic                            commFault,
    output logic                            commIdle
);

    // ------------------------------------------------------------------
    // Per-channel parameter store
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0][OPT_W-1:0] opts_q,     opts_d;
    logic [NUM_CH-1:0][15:0]      low_q,      low_d;
    logic [NUM_CH-1:0][15:0]      high_q,     high_d;
    logic [NUM_CH-1:0][15:0]      sclLow_q,   sclLow_d;
    logic [NUM_CH-1:0][15:0]      sclHigh_q,  sclHigh_d;
    logic [NUM_CH-1:0][15:0]      faultVal_q, faultVal_d;
    logic [NUM_CH-1:0][15:0]      idleVal_q,  idleVal_d;

    // Decodes a parameter write into the addressed channel's field.
    always_comb begin
        opts_d     = opts_q;
        low_d      = low_q;
        high_d     = high_q;
        sclLow_d   = sclLow_q;
        sclHigh_d  = sclHigh_q;
        faultVal_d = faultVal_q;
        idleVal_d  = idleVal_q;
        if (parWrite) begin
            unique case (parSel)
                PAR_OPTIONS:   opts_d[parChan]     = parData[OPT_W-1:0];
                PAR_LOW:       low_d[parChan]      = parData;
                PAR_HIGH:      high_d[parChan]     = parData;
                PAR_SCL_LOW:   sclLow_d[parChan]   = acl_clamp(parData, SCL_LOW_MIN,
                                                               SCL_LOW_MAX);  // [R2]
                PAR_SCL_HIGH:  sclHigh_d[parChan]  = acl_clamp(parData, SCL_HIGH_MIN,
                                                               SCL_HIGH_MAX); // [R14]
                PAR_FAULT_VAL: faultVal_d[parChan] = parData;
                PAR_IDLE_VAL:  idleVal_d[parChan]  = parData;
                default: ;
            endcase
        end
    end

    // Holds the parameters; checks and substitution start disabled.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int c = 0; c < NUM_CH; c++) begin
                opts_q[c]     <= OPT_RST;
                low_q[c]      <= PLAIN_LOW_RST;
                high_q[c]     <= PLAIN_HIGH_RST;
                sclLow_q[c]   <= SCL_LOW_RST;  // [R2]
                sclHigh_q[c]  <= SCL_HIGH_RST; // [R14]
                faultVal_q[c] <= SUBST_RST;
                idleVal_q[c]  <= SUBST_RST;
            end
        end else begin
            opts_q     <= opts_d;
            low_q      <= low_d;
            high_q     <= high_d;
            sclLow_q   <= sclLow_d;
            sclHigh_q  <= sclHigh_d;
            faultVal_q <= faultVal_d;
            idleVal_q  <= idleVal_d;
        end
    end

    // ------------------------------------------------------------------
    // Connection check and communication state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CLOSED = 2'b00,
        ST_RUN    = 2'b01,
        ST_IDLE   = 2'b10,
        ST_FAULT  = 2'b11
    } acl_dev_st_t;

    acl_dev_st_t           state_q, state_d;
    logic [CNT_W-1:0]      wdog_q,  wdog_d;
    logic                  connOk;
    logic                  wdogExpired;

    // Accepts only the fixed instances and the node's exact sizes.
    assign connOk = link.connOpen
                    && (link.inInst  == INST_INPUT)       // [R9]
                    && (link.outInst == INST_OUTPUT)      // [R9]
                    && (link.cfgInst == INST_CONFIG)      // [R9]
                    && (link.cfgSize == CFG_SIZE_ZERO)    // [R10]
                    && (link.inSize  == NODE_IN_BYTES)    // [R11]
                    && (link.outSize == NODE_OUT_BYTES);  // [R11]
    assign link.connAccepted = connOk;
    assign wdogExpired = (wdog_q == CNT_W'(WATCHDOG - 1));

    // Tracks run, idle and fault from the frames and the watchdog.
    always_comb begin
        state_d = state_q;
        wdog_d  = wdog_q;
        if (link.outValid || state_q == ST_CLOSED || state_q == ST_FAULT) begin
            wdog_d = '0;
        end else begin
            wdog_d = wdog_q + CNT_W'(1);
        end
        unique case (state_q)
            ST_CLOSED,
            ST_FAULT: begin
                if (connOk && link.outValid) begin
                    state_d = link.runMode ? ST_RUN : ST_IDLE;
                end
            end
            ST_RUN,
            ST_IDLE: begin
                if (!connOk || wdogExpired) begin
                    state_d = ST_FAULT;
                end else if (link.outValid) begin
                    state_d = link.runMode ? ST_RUN : ST_IDLE;
                end
            end
        endcase
    end

    // Registers the communication state and the watchdog.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_CLOSED;
            wdog_q  <= '0;
        end else begin
            state_q <= state_d;
            wdog_q  <= wdog_d;
        end
    end

    assign commFault = (state_q == ST_FAULT);
    assign commIdle  = (state_q == ST_IDLE);

    // ------------------------------------------------------------------
    // Output values, substitution and input reply
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0][15:0]    dac_q, dac_d;
    logic                       inValid_q, inValid_d;
    logic [NUM_CH*VAL_W-1:0]    inData_q,  inData_d;
    logic                       handheld;

    assign handheld = (holdPriority == PRIO_HANDHELD);

    // Takes run data, or substitutes per channel; otherwise holds last.
    always_comb begin
        dac_d     = dac_q;
        inValid_d = 1'b0;
        inData_d  = inData_q;
        for (int c = 0; c < NUM_CH; c++) begin
            if (state_d == ST_RUN && link.outValid) begin
                dac_d[c] = link.outData[c*VAL_W +: VAL_W];
            end else if (state_d == ST_FAULT && handheld                  // [R5]
                         && opts_q[c][OPT_FAULT_EN]) begin
                dac_d[c] = faultVal_q[c];                                  // [R3]
            end else if (state_d == ST_IDLE && handheld                   // [R5]
                         && opts_q[c][OPT_IDLE_EN]) begin
                dac_d[c] = idleVal_q[c];                                   // [R4]
            end
        end
        if (connOk && link.outValid) begin
            inValid_d = 1'b1;
            inData_d  = adcValue;                                          // [R9]
        end
    end

    // Registers output values and the reply frame.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dac_q     <= '0;
            inValid_q <= 1'b0;
            inData_q  <= '0;
        end else begin
            dac_q     <= dac_d;
            inValid_q <= inValid_d;
            inData_q  <= inData_d;
        end
    end

    assign dacValue     = dac_q;
    assign link.inValid = inValid_q;
    assign link.inData  = inData_q;

    // ------------------------------------------------------------------
    // Limit checks on inputs and outputs
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0][15:0] effLow;
    logic [NUM_CH-1:0][15:0] effHigh;
    logic [NUM_CH-1:0]       inLow, inHigh, outLow, outHigh;

    // Scaled format swaps in the scale bounds.
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            effLow[c]  = (dataFormat == FMT_SCALED) ? sclLow_q[c]  : low_q[c];   // [R6]
            effHigh[c] = (dataFormat == FMT_SCALED) ? sclHigh_q[c] : high_q[c];  // [R6]
        end
    end

    for (genvar g = 0; g < NUM_CH; g++) begin : gChk
        acl_limit_check uIn (
            .clk        (clk),
            .rst_n      (rst_n),
            .value      (adcValue[g]),
            .lowBound   (effLow[g]),
            .highBound  (effHigh[g]),
            .lowEn      (opts_q[g][OPT_LOW_EN]),
            .highEn     (opts_q[g][OPT_HIGH_EN]),
            .dataFormat (dataFormat),
            .lowErr     (inLow[g]),
            .highErr    (inHigh[g])
        );
        acl_limit_check uOut (
            .clk        (clk),
            .rst_n      (rst_n),
            .value      (dac_q[g]),
            .lowBound   (effLow[g]),
            .highBound  (effHigh[g]),
            .lowEn      (opts_q[g][OPT_LOW_EN]),
            .highEn     (opts_q[g][OPT_HIGH_EN]),
            .dataFormat (dataFormat),
            .lowErr     (outLow[g]),
            .highErr    (outHigh[g])
        );
    end

    assign inChanErr    = inLow | inHigh;    // [R1]
    assign outChanErr   = outLow | outHigh;  // [R13]
    assign link.chanErr = {outChanErr, inChanErr};

endmodule : acl_device_end

// >>> acl_host_end.sv
`timescale 1ns/1ps
module acl_host_end
    import acl_pkg::*;
#(
    parameter int CYCLE = CYCLE_CLKS
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    acl_link_if.host                      link,
    input  wire logic                     openReq,
    input  wire logic                     runReq,
    input  wire logic [NUM_CH-1:0][15:0]  userOut,
    output logic [NUM_CH-1:0][15:0]       userIn,
    output logic                          inFresh,
    output logic                          connUp,
    output logic [2*NUM_CH-1:0]           chanErr
);

    typedef enum logic {
        H_OFF = 1'b0,
        H_ON  = 1'b1
    } acl_host_st_t;

    acl_host_st_t               state_q, state_d;
    logic [CNT_W-1:0]           cnt_q,   cnt_d;
    logic                       outValid_q, outValid_d;
    logic [NUM_CH*VAL_W-1:0]    outData_q,  outData_d;
    logic                       runMode_q,  runMode_d;
    logic [NUM_CH-1:0][15:0]    userIn_q,   userIn_d;
    logic                       fresh_q,    fresh_d;
    logic [2*NUM_CH-1:0]        err_q,      err_d;

    // ------------------------------------------------------------------
    // Connection parameters
    // ------------------------------------------------------------------
    // Fixed instances, zero configuration size, sizes of the node.
    assign link.inInst   = INST_INPUT;      // [R9]
    assign link.outInst  = INST_OUTPUT;     // [R9]
    assign link.cfgInst  = INST_CONFIG;     // [R9]
    assign link.cfgSize  = CFG_SIZE_ZERO;   // [R10]
    assign link.inSize   = NODE_IN_BYTES;   // [R11] [R12]
    assign link.outSize  = NODE_OUT_BYTES;  // [R11] [R12]
    assign link.connOpen = (state_q == H_ON);

    // ------------------------------------------------------------------
    // Cyclic exchange
    // ------------------------------------------------------------------
    // Sends one output frame per cycle period and captures replies.
    always_comb begin
        state_d    = openReq ? H_ON : H_OFF;
        cnt_d      = cnt_q;
        outValid_d = 1'b0;
        outData_d  = outData_q;
        runMode_d  = runMode_q;
        userIn_d   = userIn_q;
        fresh_d    = 1'b0;
        err_d      = err_q;
        if (state_q == H_ON && link.connAccepted) begin
            if (cnt_q == CNT_W'(CYCLE - 1)) begin
                cnt_d      = '0;
                outValid_d = 1'b1;
                outData_d  = userOut;
                runMode_d  = runReq;
            end else begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end else begin
            cnt_d = '0;
        end
        if (link.inValid) begin
            userIn_d = link.inData;
            fresh_d  = 1'b1;
            err_d    = link.chanErr;
        end
    end

    // Registers the exchange state.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q    <= H_OFF;
            cnt_q      <= '0;
            outValid_q <= 1'b0;
            outData_q  <= '0;
            runMode_q  <= 1'b0;
            userIn_q   <= '0;
            fresh_q    <= 1'b0;
            err_q      <= '0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            outValid_q <= outValid_d;
            outData_q  <= outData_d;
            runMode_q  <= runMode_d;
            userIn_q   <= userIn_d;
            fresh_q    <= fresh_d;
            err_q      <= err_d;
        end
    end

    assign link.outValid = outValid_q;
    assign link.outData  = outData_q;
    assign link.runMode  = runMode_q;
    assign userIn        = userIn_q;
    assign inFresh       = fresh_q;
    assign connUp        = link.connAccepted;
    assign chanErr       = err_q;

endmodule : acl_host_end

// >>> acl_props.sv
`timescale 1ns/1ps
module acl_props
    import acl_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    connOpen,
    input wire logic [7:0]              inInst,
    input wire logic [7:0]              outInst,
    input wire logic [7:0]              cfgInst,
    input wire logic [7:0]              inSize,
    input wire logic [7:0]              outSize,
    input wire logic [7:0]              cfgSize,
    input wire logic                    outValid,
    input wire logic                    connAccepted,
    input wire logic                    inValid,
    input wire logic [NUM_CH*VAL_W-1:0] inData,
    input wire logic [2*NUM_CH-1:0]     chanErr
);
    // Every check runs on the one link clock and rests during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    inst_match_a: assert property (connAccepted |-> inInst == INST_INPUT &&
        outInst == INST_OUTPUT && cfgInst == INST_CONFIG) else $error("bad instance accepted");
    size_match_a: assert property (connAccepted |-> cfgSize == CFG_SIZE_ZERO &&
        inSize == NODE_IN_BYTES && outSize == NODE_OUT_BYTES) else $error("bad size accepted");
    open_needed_a: assert property (!connOpen |-> !connAccepted)
        else $error("accepted without open");
    reply_follows_a: assert property (outValid && connAccepted |=> inValid)
        else $error("frame not answered");
    reply_cause_a: assert property (inValid |-> $past(outValid && connAccepted))
        else $error("reply without frame");
    reply_single_a: assert property (inValid |=> !inValid)
        else $error("reply longer than a cycle");
    // The bench runs the host with a cycle of eight clocks.
    frame_gap_a: assert property (outValid |=> !outValid [*7])
        else $error("frames too close");
    data_hold_a: assert property (!inValid |-> $stable(inData))
        else $error("input data moved without reply");
    err_reset_a: assert property (!$past(rst_n) |-> chanErr == '0)
        else $error("error flag set out of reset");
endmodule : acl_props

// >>> acl_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module acl_bench
    import acl_pkg::*;
;
    logic                   clk = 1'b0, rst_n = 1'b0, openReq = 1'b0, runReq = 1'b0;
    logic                   parWrite = 1'b0, parChan = 1'b0, commFault, commIdle, inFresh, connUp;
    acl_fmt_t               dataFormat = FMT_TWOS;
    acl_prio_t              holdPriority = PRIO_NETWORK;
    acl_par_t               parSel = PAR_OPTIONS;
    logic [15:0]            parData = 16'h0000;
    logic [NUM_CH-1:0][15:0] adcValue = '0, userOut = '0, dacValue, userIn;
    logic [NUM_CH-1:0]      inChanErr, outChanErr;
    logic [2*NUM_CH-1:0]    chanErr;
    int                     n_mismatch = 0, n_checks = 0;

    // The clock toggles every 20 ns, half of its 40 ns period.
    always #20 clk = ~clk;

    acl_link_if acl_link_if_i ();
    acl_device_end #(.WATCHDOG(40)) acl_device_end_i (.clk, .rst_n, .link(acl_link_if_i),
        .dataFormat, .holdPriority, .parWrite, .parChan, .parSel, .parData, .adcValue,
        .dacValue, .inChanErr, .outChanErr, .commFault, .commIdle);
    acl_host_end #(.CYCLE(8)) acl_host_end_i (.clk, .rst_n, .link(acl_link_if_i), .openReq,
        .runReq, .userOut, .userIn, .inFresh, .connUp, .chanErr);
    acl_props acl_props_i (.clk, .rst_n, .connOpen(acl_link_if_i.connOpen),
        .inInst(acl_link_if_i.inInst), .outInst(acl_link_if_i.outInst),
        .cfgInst(acl_link_if_i.cfgInst), .inSize(acl_link_if_i.inSize),
        .outSize(acl_link_if_i.outSize), .cfgSize(acl_link_if_i.cfgSize),
        .outValid(acl_link_if_i.outValid), .connAccepted(acl_link_if_i.connAccepted),
        .inValid(acl_link_if_i.inValid), .inData(acl_link_if_i.inData),
        .chanErr(acl_link_if_i.chanErr));

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // Writes one parameter and lets the error flags settle.
    task par(input logic c, input acl_par_t s, input logic [15:0] d);
        @(posedge clk);
        parWrite <= 1'b1; parChan <= c; parSel <= s; parData <= d;
        @(posedge clk);
        parWrite <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : par

    // Waits a bounded time for a fresh reply at the host.
    task wait_fresh;
        repeat (100) begin @(posedge clk); #1; if (inFresh === 1'b1) return; end
        n_mismatch++;
        $display("FAIL %0t no reply", $time);
        test_done();
    endtask : wait_fresh

    // Drives one input channel and checks its settled error flag.
    task adc(input int ch, input logic [15:0] d, input logic e);
        @(posedge clk);
        adcValue[ch] <= d;
        repeat (2) @(posedge clk);
        #1;
        `CHK(inChanErr[ch], e)
    endtask : adc

    task sc_run;
        `CHK(chanErr, 4'h0)
        `CHK(connUp, 1'b0)
        @(posedge clk);
        userOut <= {16'h0abc, 16'h1234}; adcValue <= {16'h0321, 16'h0123};
        openReq <= 1'b1; runReq <= 1'b1;
        wait_fresh();
        `CHK(connUp, 1'b1)
        `CHK(userIn, adcValue)
        `CHK(dacValue, userOut)
    endtask : sc_run

    task sc_limits;
        par(1'b0, PAR_LOW, 16'h0100);
        par(1'b0, PAR_HIGH, 16'h0200);
        par(1'b0, PAR_OPTIONS, 16'h0003);
        `CHK(outChanErr, 2'b01)
        adc(0, 16'hff00, 1'b1);
        wait_fresh();
        wait_fresh();
        `CHK(chanErr, 4'b0101)
        adc(0, 16'h0150, 1'b0);
        adc(0, 16'h0201, 1'b1);
    endtask : sc_limits

    task sc_formats;
        par(1'b0, PAR_OPTIONS, 16'h0002);
        adc(0, 16'h8150, 1'b0);
        @(posedge clk);
        dataFormat <= FMT_OFFSET_BIN;
        adc(0, 16'h8150, 1'b1);
        @(posedge clk);
        dataFormat <= FMT_SIGN_MAG;
        adc(0, 16'h8150, 1'b0);
        adc(0, 16'h0250, 1'b1);
    endtask : sc_formats

    task sc_scaled;
        @(posedge clk);
        dataFormat <= FMT_SCALED;
        par(1'b1, PAR_SCL_LOW, 16'h8000);
        par(1'b1, PAR_OPTIONS, 16'h0003);
        adc(1, 16'h8000, 1'b1);
        adc(1, 16'h8001, 1'b0);
        adc(1, 16'h03e8, 1'b0);
        adc(1, 16'h03e9, 1'b1);
        `CHK(outChanErr[1], 1'b1)
    endtask : sc_scaled

    task sc_subst;
        @(posedge clk);
        userOut <= {16'h0555, 16'h0666}; runReq <= 1'b0;
        par(1'b0, PAR_OPTIONS, 16'h000c);
        wait_fresh();
        wait_fresh();
        `CHK(dacValue, {16'h0abc, 16'h1234})
        par(1'b0, PAR_IDLE_VAL, 16'h0111);
        par(1'b0, PAR_FAULT_VAL, 16'h0222);
        @(posedge clk);
        holdPriority <= PRIO_HANDHELD; runReq <= 1'b1;
        wait_fresh();
        wait_fresh();
        `CHK(dacValue, userOut)
        @(posedge clk);
        runReq <= 1'b0;
        wait_fresh();
        wait_fresh();
        `CHK(dacValue, {16'h0555, 16'h0111})
        `CHK(commIdle, 1'b1)
        @(posedge clk);
        openReq <= 1'b0;
        for (int i = 0; i < 50 && commFault !== 1'b1; i++) begin @(posedge clk); #1; end
        `CHK(commFault, 1'b1)
        `CHK(dacValue, {16'h0555, 16'h0222})
    endtask : sc_subst

    // Main sequence: reset, then every scenario in turn.
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        sc_run();
        sc_limits();
        sc_formats();
        sc_scaled();
        sc_subst();
        test_done();
    end
endmodule : acl_bench
